// File: rtl/tis_pkg.sv
/*
  Constants, states and carrier types for the terminal initialization sequencer.
  Assumes a single 40 MHz clock and message-decode strobes from the MAC on that clock.
*/
`default_nettype none
package tis_pkg;
  // ------------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------------
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CH_W = 3;
  localparam int unsigned RSSI_W = 8;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SYNC_TIMEOUT_MS = 100;
  localparam int unsigned SYNC_TIMEOUT_CYC = CLK_HZ / 1000 * SYNC_TIMEOUT_MS;
  localparam int unsigned TMR_W = 32;
  localparam logic [1:0] PHY_MODE_CTRL = 2'h0;
  localparam logic [1:0] PHY_MODE_BCAST = 2'h1;
  localparam logic [15:0] SECTOR_ID_RESET = 16'h0000;

  typedef enum logic [3:0] {
    TIS_MEASURE, TIS_SORT, TIS_TUNE, TIS_SYNC, TIS_SECTOR, TIS_PARAMS,
    TIS_WAIT_INVITE, TIS_RANGING, TIS_RANGE_DONE, TIS_PHY_CAPS, TIS_AUTH,
    TIS_OTHER_CAPS, TIS_OPER
  } tis_state_t;

  // ------------------------------------------------------------------
  // Downlink events from the MAC decoder
  // ------------------------------------------------------------------
  typedef struct packed {
    logic ctrl_zone_ok;
    logic ctrl_zone_fail;
    logic map_ok;
    logic broadcast_info_msg;
    logic ranging_invite_msg;
    logic ranging_success_msg;
    logic other_msg;
    logic phy_caps_done;
    logic auth_done;
    logic other_caps_done;
    logic init_done_status;
  } tis_dl_evt_t;

  typedef struct packed {
    logic [9:0] terminal_id;
    logic [15:0] basic_cid;
    logic [15:0] primary_cid;
    logic [15:0] secondary_cid;
    logic [12:0] timing_offset;
    logic [5:0] power_level;
  } tis_ranging_t;

  typedef struct packed {
    logic [5:0] power_step;
    logic [7:0] invite_period;
  } tis_bcast_t;
endpackage : tis_pkg
`default_nettype wire

// File: rtl/tis_sequencer.sv
/*
  Initialization sequencer: channel scan and sort, sync with timeout, sector check,
  broadcast parameter capture, ranging gating, negotiation tracking, operational status.
  Assumes the radio front end supplies per-channel strength and sync/decode events as
  same-clock strobes; the link-lost and power-interruption inputs are asynchronous.
*/
`default_nettype none
module tis_sequencer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Channel measurement
  input wire logic meas_valid_i,
  input wire logic [tis_pkg::CH_W-1:0] meas_ch_i,
  input wire logic [tis_pkg::RSSI_W-1:0] meas_rssi_i,
  // Stored channel list and its replacement
  input wire logic [tis_pkg::NUM_CH-1:0] nv_ch_mask_i,
  input wire logic chan_list_valid_i,
  input wire logic [tis_pkg::NUM_CH-1:0] chan_list_mask_i,
  // Identity
  input wire logic [15:0] nv_sector_id_i,
  input wire logic [15:0] rx_sector_id_i,
  // Downlink events
  input wire tis_pkg::tis_dl_evt_t dl_evt_i,
  input wire tis_pkg::tis_bcast_t bcast_i,
  input wire tis_pkg::tis_ranging_t ranging_i,
  input wire logic ranging_grant_i,
  input wire logic regular_grant_i,
  // Asynchronous restart causes
  input wire logic link_lost_i,
  input wire logic power_interruption_i,
  // Tuning and decode control
  output logic measure_req_o,
  output logic [tis_pkg::CH_W-1:0] tune_ch_o,
  output logic [1:0] ctrl_zone_mode_o,
  output logic [1:0] bcast_mode_o,
  // Transmit permission
  output logic tx_ranging_en_o,
  output logic tx_regular_en_o,
  // Results
  output tis_pkg::tis_bcast_t bcast_o,
  output tis_pkg::tis_ranging_t ranging_o,
  output logic synced_o,
  output logic operational_o,
  output tis_pkg::tis_state_t state_o
);
  // ------------------------------------------------------------------
  // Restart synchronisers
  // ------------------------------------------------------------------
  logic [1:0] lost_sync_reg;
  logic [1:0] psi_sync_reg;
  logic link_lost;
  logic power_interruption;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lost_sync_reg <= 2'h0;
      psi_sync_reg <= 2'h0;
    end else begin
      lost_sync_reg <= {lost_sync_reg[0], link_lost_i};
      psi_sync_reg <= {psi_sync_reg[0], power_interruption_i};
    end
  end
  assign link_lost = lost_sync_reg[1];
  assign power_interruption = psi_sync_reg[1];

  // ------------------------------------------------------------------
  // Channel table and sort
  // ------------------------------------------------------------------
  tis_pkg::tis_state_t state_reg;
  logic [tis_pkg::NUM_CH-1:0] list_reg;
  logic list_loaded_reg;
  logic [tis_pkg::RSSI_W-1:0] rssi_reg [tis_pkg::NUM_CH];
  logic [tis_pkg::CH_W-1:0] order_reg [tis_pkg::NUM_CH];
  logic [tis_pkg::CH_W-1:0] sort_pass_reg;
  logic [tis_pkg::CH_W-1:0] pos_reg;
  logic [tis_pkg::CH_W-1:0] prev_ch_reg;
  logic have_prev_reg;
  logic reinit_reg;
  logic [tis_pkg::CH_W-1:0] cur_ch;
  logic last_pos;
  logic reject;

  assign cur_ch = order_reg[pos_reg];
  assign last_pos = (pos_reg == tis_pkg::CH_W'(tis_pkg::NUM_CH - 1));

  // Stored list used until a channel list message replaces it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      list_reg <= '0;
      list_loaded_reg <= 1'b0;
    end else if (chan_list_valid_i) begin
      list_reg <= chan_list_mask_i;
      list_loaded_reg <= 1'b1;
    end else if (!list_loaded_reg) begin
      list_reg <= nv_ch_mask_i;
      list_loaded_reg <= 1'b1;
    end
  end

  // Odd-even transposition sort, strongest first; channels off the list sort last
  genvar gi;
  generate
    for (gi = 0; gi < tis_pkg::NUM_CH; gi++) begin : g_ch
      // Neighbour indices wrap so that no constant index leaves the table
      localparam int unsigned NXT = (gi + 1) % tis_pkg::NUM_CH;
      localparam int unsigned PRV = (gi + tis_pkg::NUM_CH - 1) % tis_pkg::NUM_CH;
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          rssi_reg[gi] <= '0;
        end else if (meas_valid_i && state_reg == tis_pkg::TIS_MEASURE
                     && meas_ch_i == tis_pkg::CH_W'(gi)) begin
          rssi_reg[gi] <= list_reg[gi] ? meas_rssi_i : '0;
        end
      end
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          order_reg[gi] <= tis_pkg::CH_W'(gi);
        end else if (state_reg == tis_pkg::TIS_MEASURE) begin
          order_reg[gi] <= tis_pkg::CH_W'(gi);
        end else if (state_reg == tis_pkg::TIS_SORT) begin
          if ((gi % 2) == sort_pass_reg[0] && gi + 1 < tis_pkg::NUM_CH) begin
            if (rssi_reg[order_reg[NXT]] > rssi_reg[order_reg[gi]]) begin
              order_reg[gi] <= order_reg[NXT];
            end
          end else if (gi > 0 && ((gi - 1) % 2) == sort_pass_reg[0]) begin
            if (rssi_reg[order_reg[gi]] > rssi_reg[order_reg[PRV]]) begin
              order_reg[gi] <= order_reg[PRV];
            end
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Sync timer
  // ------------------------------------------------------------------
  logic [tis_pkg::TMR_W-1:0] sync_tmr_reg;
  logic sync_timeout;
  logic frame_sync_reg;
  logic map_seen_reg;
  assign sync_timeout = (sync_tmr_reg == tis_pkg::TMR_W'(tis_pkg::SYNC_TIMEOUT_CYC - 1));
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_tmr_reg <= '0;
    end else if (state_reg == tis_pkg::TIS_SYNC && !map_seen_reg) begin
      sync_tmr_reg <= sync_tmr_reg + 1'b1;
    end else begin
      sync_tmr_reg <= '0;
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_sync_reg <= 1'b0;
      map_seen_reg <= 1'b0;
    end else if (state_reg == tis_pkg::TIS_MEASURE || state_reg == tis_pkg::TIS_TUNE) begin
      frame_sync_reg <= 1'b0;
      map_seen_reg <= 1'b0;
    end else begin
      if (dl_evt_i.ctrl_zone_ok) begin
        frame_sync_reg <= 1'b1;
      end else if (dl_evt_i.ctrl_zone_fail) begin
        frame_sync_reg <= 1'b0;
      end
      if (dl_evt_i.map_ok) begin
        map_seen_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Step sequencing
  // ------------------------------------------------------------------
  logic invite_lock_reg;
  logic restart;
  assign restart = link_lost || power_interruption;
  assign reject = (state_reg == tis_pkg::TIS_SECTOR) && (rx_sector_id_i != nv_sector_id_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= tis_pkg::TIS_MEASURE;
      pos_reg <= '0;
      sort_pass_reg <= '0;
      reinit_reg <= 1'b0;
    end else if (power_interruption) begin
      state_reg <= tis_pkg::TIS_MEASURE;
      pos_reg <= '0;
      reinit_reg <= 1'b0;
    end else if (link_lost && state_reg != tis_pkg::TIS_MEASURE) begin
      state_reg <= have_prev_reg ? tis_pkg::TIS_TUNE : tis_pkg::TIS_MEASURE;
      reinit_reg <= have_prev_reg;
      pos_reg <= '0;
    end else begin
      unique case (state_reg)
        tis_pkg::TIS_MEASURE: begin
          sort_pass_reg <= '0;
          if (meas_valid_i && meas_ch_i == tis_pkg::CH_W'(tis_pkg::NUM_CH - 1)) begin
            state_reg <= tis_pkg::TIS_SORT;
          end
        end
        tis_pkg::TIS_SORT: begin
          sort_pass_reg <= sort_pass_reg + 1'b1;
          if (sort_pass_reg == tis_pkg::CH_W'(tis_pkg::NUM_CH - 1)) begin
            pos_reg <= '0;
            state_reg <= tis_pkg::TIS_TUNE;
          end
        end
        tis_pkg::TIS_TUNE: state_reg <= tis_pkg::TIS_SYNC;
        tis_pkg::TIS_SYNC: begin
          if (map_seen_reg && frame_sync_reg) begin
            state_reg <= tis_pkg::TIS_SECTOR;
          end else if (sync_timeout) begin
            if (reinit_reg) begin
              reinit_reg <= 1'b0;
              state_reg <= tis_pkg::TIS_TUNE;
            end else if (last_pos) begin
              state_reg <= tis_pkg::TIS_MEASURE;
            end else begin
              pos_reg <= pos_reg + 1'b1;
              state_reg <= tis_pkg::TIS_TUNE;
            end
          end
        end
        tis_pkg::TIS_SECTOR: begin
          if (!reject) begin
            state_reg <= tis_pkg::TIS_PARAMS;
          end else if (reinit_reg) begin
            reinit_reg <= 1'b0;
            state_reg <= tis_pkg::TIS_TUNE;
          end else if (last_pos) begin
            state_reg <= tis_pkg::TIS_MEASURE;
          end else begin
            pos_reg <= pos_reg + 1'b1;
            state_reg <= tis_pkg::TIS_TUNE;
          end
        end
        tis_pkg::TIS_PARAMS: begin
          if (dl_evt_i.broadcast_info_msg) begin
            state_reg <= tis_pkg::TIS_WAIT_INVITE;
          end
        end
        tis_pkg::TIS_WAIT_INVITE: begin
          if (dl_evt_i.ranging_invite_msg && !invite_lock_reg) begin
            state_reg <= tis_pkg::TIS_RANGING;
          end
        end
        tis_pkg::TIS_RANGING: begin
          if (dl_evt_i.ranging_success_msg) begin
            state_reg <= tis_pkg::TIS_RANGE_DONE;
          end
        end
        tis_pkg::TIS_RANGE_DONE: begin
          if (dl_evt_i.other_msg) begin
            state_reg <= tis_pkg::TIS_PHY_CAPS;
          end
        end
        tis_pkg::TIS_PHY_CAPS: if (dl_evt_i.phy_caps_done) state_reg <= tis_pkg::TIS_AUTH;
        tis_pkg::TIS_AUTH: if (dl_evt_i.auth_done) state_reg <= tis_pkg::TIS_OTHER_CAPS;
        tis_pkg::TIS_OTHER_CAPS: begin
          if (dl_evt_i.other_caps_done) begin
            state_reg <= tis_pkg::TIS_OPER;
          end
        end
        tis_pkg::TIS_OPER: begin
          if (!frame_sync_reg) begin
            reinit_reg <= 1'b1;
            state_reg <= tis_pkg::TIS_TUNE;
          end else if (dl_evt_i.ranging_invite_msg && !invite_lock_reg) begin
            state_reg <= tis_pkg::TIS_RANGING;
          end
        end
      endcase
    end
  end

  // Previous channel remembered for re-initialization
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_ch_reg <= '0;
      have_prev_reg <= 1'b0;
    end else if (state_reg == tis_pkg::TIS_OPER) begin
      prev_ch_reg <= cur_ch;
      have_prev_reg <= 1'b1;
    end
  end

  // Invitation lock until init done status arrives
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      invite_lock_reg <= 1'b0;
    end else if (restart) begin
      invite_lock_reg <= 1'b0;
    end else if (dl_evt_i.ranging_invite_msg && !invite_lock_reg &&
                 (state_reg == tis_pkg::TIS_WAIT_INVITE || state_reg == tis_pkg::TIS_OPER)) begin
      invite_lock_reg <= 1'b1;
    end else if (dl_evt_i.init_done_status) begin
      invite_lock_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Captured parameters and outputs
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcast_o <= '0;
      ranging_o <= '0;
    end else begin
      if (dl_evt_i.broadcast_info_msg && state_reg != tis_pkg::TIS_MEASURE) begin
        bcast_o <= bcast_i;
      end
      if (dl_evt_i.ranging_success_msg && state_reg == tis_pkg::TIS_RANGING) begin
        ranging_o <= ranging_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      measure_req_o <= 1'b0;
      tune_ch_o <= '0;
      ctrl_zone_mode_o <= tis_pkg::PHY_MODE_CTRL;
      bcast_mode_o <= tis_pkg::PHY_MODE_BCAST;
      tx_ranging_en_o <= 1'b0;
      tx_regular_en_o <= 1'b0;
      synced_o <= 1'b0;
      operational_o <= 1'b0;
      state_o <= tis_pkg::TIS_MEASURE;
    end else begin
      measure_req_o <= (state_reg == tis_pkg::TIS_MEASURE);
      tune_ch_o <= reinit_reg ? prev_ch_reg : cur_ch;
      ctrl_zone_mode_o <= tis_pkg::PHY_MODE_CTRL;
      bcast_mode_o <= tis_pkg::PHY_MODE_BCAST;
      tx_ranging_en_o <= ranging_grant_i && !restart &&
                         (state_reg == tis_pkg::TIS_RANGING ||
                          state_reg == tis_pkg::TIS_RANGE_DONE);
      tx_regular_en_o <= regular_grant_i && !restart && frame_sync_reg &&
                         (state_reg == tis_pkg::TIS_PHY_CAPS || state_reg == tis_pkg::TIS_AUTH ||
                          state_reg == tis_pkg::TIS_OTHER_CAPS ||
                          state_reg == tis_pkg::TIS_OPER);
      synced_o <= frame_sync_reg;
      operational_o <= (state_reg == tis_pkg::TIS_OPER) && frame_sync_reg && !restart;
      state_o <= state_reg;
    end
  end
endmodule : tis_sequencer
`default_nettype wire

// File: tb/tis_sequencer_props.sv
/*
  Checker for the init sequencer: decode modes, ranging gating, step order, sync.
  Assumes it is bound to the sequencer top and sees only its ports.
*/
`default_nettype none
module tis_sequencer_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Watched inputs
  input wire tis_pkg::tis_dl_evt_t dl_evt_i,
  input wire logic ranging_grant_i,
  // Watched outputs
  input wire logic [1:0] ctrl_zone_mode_o,
  input wire logic [1:0] bcast_mode_o,
  input wire logic tx_ranging_en_o,
  input wire logic tx_regular_en_o,
  input wire logic synced_o,
  input wire logic operational_o,
  input wire tis_pkg::tis_state_t state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_done_seen;
    state_o == tis_pkg::TIS_RANGE_DONE && dl_evt_i.other_msg;
  endsequence
  sequence s_phy_reached;
    ##[1:2] state_o == tis_pkg::TIS_PHY_CAPS;
  endsequence
  a_ctrl_zone_mode: assert property (ctrl_zone_mode_o == tis_pkg::PHY_MODE_CTRL)
    else $error("control zone mode wrong");
  a_bcast_mode: assert property (bcast_mode_o == tis_pkg::PHY_MODE_BCAST)
    else $error("broadcast mode wrong");
  a_rng_tx_gate: assert property (tx_ranging_en_o |-> $past(ranging_grant_i))
    else $error("ranging transmit without grant");
  a_rng_no_regular: assert property (state_o == tis_pkg::TIS_RANGING |-> !tx_regular_en_o)
    else $error("regular transmit during ranging");
  a_params_order: assert property (state_o == tis_pkg::TIS_PARAMS |->
    $past(state_o) inside {tis_pkg::TIS_SECTOR, tis_pkg::TIS_PARAMS})
    else $error("parameter step entered out of order");
  a_phy_order: assert property (state_o == tis_pkg::TIS_PHY_CAPS |->
    $past(state_o) inside {tis_pkg::TIS_RANGE_DONE, tis_pkg::TIS_PHY_CAPS})
    else $error("capability step entered out of order");
  a_rng_finish: assert property (s_done_seen |-> s_phy_reached)
    else $error("ranging end did not advance");
  a_sync_cause: assert property ($rose(synced_o) |->
    $past(dl_evt_i.ctrl_zone_ok) || $past(dl_evt_i.ctrl_zone_ok, 2))
    else $error("sync without decoded control zone");
  a_sync_drop: assert property (dl_evt_i.ctrl_zone_fail && !dl_evt_i.ctrl_zone_ok |->
    ##[1:2] !synced_o)
    else $error("sync kept after decode failure");
  a_oper_after: assert property (operational_o |-> state_o == tis_pkg::TIS_OPER)
    else $error("operational outside final step");
endmodule : tis_sequencer_props

bind tis_sequencer tis_sequencer_props i_props (.ref_clk_i, .nrst_i, .dl_evt_i,
  .ranging_grant_i, .ctrl_zone_mode_o, .bcast_mode_o, .tx_ranging_en_o,
  .tx_regular_en_o, .synced_o, .operational_o, .state_o);
`default_nettype wire

// File: tb/tis_ap_model.sv
/*
  Access point model: downlink event pulses, periodic broadcast info, grants.
  Assumes the bench calls pulse() for each commanded downlink message.
*/
`default_nettype none
module tis_ap_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Bench control
  input wire logic bc_en_i,
  // Toward the terminal
  output tis_pkg::tis_dl_evt_t dl_evt_o,
  output logic ranging_grant_o,
  output logic regular_grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  tis_pkg::tis_dl_evt_t pend = '0;
  logic bc_tick;
  logic rng_on = 1'b0;
  logic reg_on = 1'b0;
  logic [3:0] per;
  assign dl_evt_o = pend | {3'h0, bc_tick, 7'h00};
  assign regular_grant_o = reg_on;
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per <= 4'h0;
      bc_tick <= 1'b0;
      ranging_grant_o <= 1'b0;
    end else begin
      per <= #2 per + 4'h1;
      bc_tick <= #2 bc_en_i && per == 4'hf;
      ranging_grant_o <= #2 rng_on && !ranging_grant_o;
    end
  end
  task pulse(input tis_pkg::tis_dl_evt_t v);
    @(posedge ref_clk_i) #2;
    pend = v;
    if (v.ranging_invite_msg) rng_on = 1'b1;
    if (v.ranging_success_msg) begin
      rng_on = 1'b0;
      reg_on = 1'b1;
    end
    @(posedge ref_clk_i) #2;
    pend = '0;
  endtask : pulse
endmodule : tis_ap_model
`default_nettype wire

// File: tb/tb_top.sv
/*
  Bench for the init sequencer: random strengths, sector miss, full init, relock.
  Assumes the access point model supplies downlink events and grants.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic meas_valid = 1'b0;
  logic bc_en = 1'b0;
  logic [2:0] meas_ch = 3'h0;
  logic [7:0] meas_rssi = 8'h00;
  logic [15:0] nv_sid = 16'h0000;
  logic [15:0] rx_sid = 16'h0000;
  logic [7:0] nv_mask = 8'hff;
  logic [7:0] lst_mask = 8'hff;
  logic lst_v = 1'b0;
  logic lnk = 1'b0;
  logic pwr = 1'b0;
  tis_pkg::tis_bcast_t bcast_i = '0;
  tis_pkg::tis_ranging_t ranging_i = '0;
  tis_pkg::tis_dl_evt_t dl_evt;
  tis_pkg::tis_bcast_t bcast_o;
  tis_pkg::tis_ranging_t ranging_o;
  tis_pkg::tis_state_t state;
  logic rgnt, ggnt, mreq, txr, txg, synced, oper;
  logic [2:0] tune_ch;
  logic [1:0] czm, bcm;
  logic [7:0] rs [8];
  int error_cnt = 0;
  int checks_done = 0;
  int b1, b2;
  always #12.5 ref_clk_i = ~ref_clk_i;
  tis_ap_model i_ap (.ref_clk_i, .nrst_i, .bc_en_i(bc_en), .dl_evt_o(dl_evt),
    .ranging_grant_o(rgnt), .regular_grant_o(ggnt));
  tis_sequencer i_dut (.ref_clk_i, .nrst_i, .meas_valid_i(meas_valid), .meas_ch_i(meas_ch),
    .meas_rssi_i(meas_rssi), .nv_ch_mask_i(nv_mask), .chan_list_valid_i(lst_v),
    .chan_list_mask_i(lst_mask), .nv_sector_id_i(nv_sid), .rx_sector_id_i(rx_sid),
    .dl_evt_i(dl_evt), .bcast_i, .ranging_i, .ranging_grant_i(rgnt), .regular_grant_i(ggnt),
    .link_lost_i(lnk), .power_interruption_i(pwr), .measure_req_o(mreq),
    .tune_ch_o(tune_ch), .ctrl_zone_mode_o(czm), .bcast_mode_o(bcm), .tx_ranging_en_o(txr),
    .tx_regular_en_o(txg), .bcast_o, .ranging_o, .synced_o(synced), .operational_o(oper),
    .state_o(state));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic int best(input int skip);
    int k = -1;
    for (int c = 0; c < 8; c++) if (c != skip && (k < 0 || rs[c] > rs[k])) k = c;
    return k;
  endfunction : best
  task scan;
    for (int c = 0; c < 8; c++) begin
      meas_valid = 1'b1;
      meas_ch = 3'(c);
      meas_rssi = rs[c];
      @(posedge ref_clk_i) #2;
    end
    meas_valid = 1'b0;
  endtask : scan
  task conclude;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task wait_st(input tis_pkg::tis_state_t s);
    int n;
    for (n = 0; n < 300 && state !== s; n++) @(posedge ref_clk_i) #1;
    if (n == 300) begin
      error_cnt++;
      $display("unexpected state exp %0d got %0d", s, state);
      conclude();
    end
  endtask : wait_st
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'h1bea));
    nv_sid = 16'($urandom);
    rx_sid = ~nv_sid;
    repeat (4) @(posedge ref_clk_i);
    #2 nrst_i = 1'b1;
    `CHK("bcast_mode", 2'h1, bcm)
    `CHK("state", tis_pkg::TIS_MEASURE, state)
    @(posedge ref_clk_i) #2;
    `CHK("measure_req", 1'b1, mreq)
    for (int c = 0; c < 8; c++) rs[c] = {5'($urandom), 3'(c)};
    scan();
    b1 = best(-1);
    b2 = best(b1);
    wait_st(tis_pkg::TIS_SYNC);
    `CHK("tune_ch", 3'(b1), tune_ch)
    i_ap.pulse(11'h500);
    wait_st(tis_pkg::TIS_SECTOR);
    `CHK("synced", 1'b1, synced)
    wait_st(tis_pkg::TIS_SYNC);
    `CHK("tune_ch", 3'(b2), tune_ch)
    rx_sid = nv_sid;
    i_ap.pulse(11'h500);
    wait_st(tis_pkg::TIS_PARAMS);
    `CHK("ctrl_mode", 2'h0, czm)
    bcast_i = 14'($urandom);
    bc_en = 1'b1;
    wait_st(tis_pkg::TIS_WAIT_INVITE);
    bc_en = 1'b0;
    `CHK("bcast", bcast_i, bcast_o)
    ranging_i = 77'({$urandom, $urandom, $urandom});
    i_ap.pulse(11'h040);
    wait_st(tis_pkg::TIS_RANGING);
    repeat (6) begin
      @(posedge ref_clk_i) #1;
      `CHK("tx_regular", 1'b0, txg)
      `CHK("tx_ranging", rgnt, txr)
    end
    i_ap.pulse(11'h040);
    `CHK("state", tis_pkg::TIS_RANGING, state)
    i_ap.pulse(11'h020);
    wait_st(tis_pkg::TIS_RANGE_DONE);
    `CHK("ranging", ranging_i, ranging_o)
    i_ap.pulse(11'h040);
    repeat (2) @(posedge ref_clk_i) #1;
    `CHK("state", tis_pkg::TIS_RANGE_DONE, state)
    i_ap.pulse(11'h010);
    wait_st(tis_pkg::TIS_PHY_CAPS);
    i_ap.pulse(11'h008);
    i_ap.pulse(11'h004);
    `CHK("operational", 1'b0, oper)
    i_ap.pulse(11'h002);
    wait_st(tis_pkg::TIS_OPER);
    @(posedge ref_clk_i) #1;
    `CHK("operational", 1'b1, oper)
    `CHK("tx_regular", 1'b1, txg)
    // Invitation while locked is ignored; after init done a new one re-ranges
    i_ap.pulse(11'h040);
    repeat (2) @(posedge ref_clk_i) #1;
    `CHK("state", tis_pkg::TIS_OPER, state)
    i_ap.pulse(11'h001);
    i_ap.pulse(11'h040);
    wait_st(tis_pkg::TIS_RANGING);
    `CHK("operational", 1'b0, oper)
    `CHK("tx_regular", 1'b0, txg)
    i_ap.pulse(11'h020);
    i_ap.pulse(11'h010);
    i_ap.pulse(11'h008);
    i_ap.pulse(11'h004);
    i_ap.pulse(11'h002);
    wait_st(tis_pkg::TIS_OPER);
    i_ap.pulse(11'h200);
    wait_st(tis_pkg::TIS_SYNC);
    `CHK("tune_ch", 3'(b2), tune_ch)
    `CHK("measure_req", 1'b0, mreq)
    `CHK("operational", 1'b0, oper)
    `CHK("tx_regular", 1'b0, txg)
    // Link loss: previous channel first, sorted list from the top on a miss
    @(posedge ref_clk_i) #2;
    lnk = 1'b1;
    @(posedge ref_clk_i) #2;
    lnk = 1'b0;
    wait_st(tis_pkg::TIS_TUNE);
    wait_st(tis_pkg::TIS_SYNC);
    `CHK("tune_ch", 3'(b2), tune_ch)
    `CHK("measure_req", 1'b0, mreq)
    rx_sid = ~nv_sid;
    i_ap.pulse(11'h500);
    wait_st(tis_pkg::TIS_SECTOR);
    wait_st(tis_pkg::TIS_SYNC);
    `CHK("tune_ch", 3'(b1), tune_ch)
    // Power interruption with a new list that drops the strongest channel
    @(posedge ref_clk_i) #2;
    pwr = 1'b1;
    lst_mask = ~(8'h01 << b1);
    lst_v = 1'b1;
    @(posedge ref_clk_i) #2;
    pwr = 1'b0;
    lst_v = 1'b0;
    wait_st(tis_pkg::TIS_MEASURE);
    @(posedge ref_clk_i) #2;
    `CHK("measure_req", 1'b1, mreq)
    scan();
    wait_st(tis_pkg::TIS_SYNC);
    `CHK("tune_ch", 3'(b2), tune_ch)
    conclude();
  end
endmodule : tb_top
`default_nettype wire
